// File: iedisp_core.sv
// Interrupt and exception dispatch: ranks requests, saves return state,
// obtains the vector and hands the table offset to the core.
// Assumes the core stalls while busy is high and pushes push_ip and
// push_flags on the stack when push_valid pulses.
//
// Overview of operation
// - Hardware interrupts only after instruction completes; the code also takes them at rep_window, mid-instruction
// - Faults serviced before the faulting instruction executes
// - Fault return address is the faulting instruction
// - Trap return address is the next instruction
// - Aborts report severe errors, imprecise location
// - Up to 256 vectors, first 32 reserved
// - Real entries 4 bytes, protected 8 bytes
// - Push address and flags, then vector, then load
// - Interrupt return restores state and resumes
// - Maskable vector comes from the acknowledge sequence
// - Maskable taken when request high and enabled
// - Repeated string moves open an interrupt window
// - Handler entry clears enable; return restores it
// - Non-maskable uses vector 2, no acknowledge
// - Nested non-maskable held, one latched until return
// - Non-maskable entry clears the interrupt enable
// - Two-byte software interrupt: any vector, trap
// - Breakpoint uses vector 3 as a trap
// - Non-maskable before maskable at the same boundary
// - Fixed vector assignments for processor exceptions
// - Page fault vector 14 points at instruction
// - Debug checks precede external request checks

`timescale 1ns/10ps

module iedisp_core
  import iedisp_pkg::*;
#(
  parameter int unsigned IP_W   = 32,
  parameter int unsigned IF_POS = IF_POS_DEFAULT
)(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // External request pins
  input  wire logic                 nmi_pin,
  input  wire logic                 maskable_irq_in,
  // Instruction stream
  input  wire logic                 instr_boundary,
  input  wire logic                 rep_window,
  input  wire logic [IP_W-1:0]      cur_ip,
  input  wire logic [IP_W-1:0]      next_ip,
  input  wire logic                 prot_mode,
  // Exceptions and software interrupts
  input  wire logic                 exc_valid,
  input  wire logic [7:0]           exc_vector,
  input  wire logic                 soft_valid,
  input  wire logic [7:0]           soft_vector,
  input  wire logic                 soft_one_byte,
  input  wire logic                 debug_trap,
  input  wire logic                 debug_fault,
  // Flags writes and interrupt return
  input  wire logic                 flags_wr_en,
  input  wire logic [31:0]          flags_wr_data,
  input  wire logic                 interrupt_return_instr,
  input  wire logic [IP_W-1:0]      interrupt_return_instr_ip,
  input  wire logic [31:0]          interrupt_return_instr_flags,
  // Acknowledge sequence answer
  input  wire logic                 inta_done,
  input  wire logic [7:0]           inta_vector,
  // Dispatch outputs
  output logic                      busy,
  output logic                      push_valid,
  output logic [IP_W-1:0]           push_ip,
  output logic [31:0]               push_flags,
  output logic                      cancel_instr,
  output logic                      inta_req,
  output logic                      vec_valid,
  output logic [7:0]                vec_num,
  output iedisp_cls_e               vec_class,
  output logic                      vec_reserved,
  output logic [TBL_OFS_W-1:0]      table_offset,
  // Return and status
  output logic                      resume_valid,
  output logic [IP_W-1:0]           resume_ip,
  output logic [31:0]               processor_flags_word,
  output logic                      nmi_in_service
);

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (IF_POS > 31) begin : g_bad_if
    $error("IF_POS must address a bit of the 32-bit flags word");
  end
  if (IP_W < 16) begin : g_bad_ipw
    $error("IP_W must be at least 16");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]          nmi_sync;
    logic                nmi_lvl;
    logic [2:0]          irq_sync;
    logic                irq_lvl;
    logic                nmi_pend;
    logic                nmi_active;
    iedisp_state_e       st;
    logic [7:0]          vec;
    logic                src_hw;
    logic                src_nmi;
    logic                src_soft;
    logic                src_dbgf;
    logic                at_rep;
    logic                prot;
    logic [IP_W-1:0]     ip_here;
    logic [IP_W-1:0]     ip_next;
    logic [31:0]         flags;
    logic                busy;
    logic                push_valid;
    logic [IP_W-1:0]     push_ip;
    logic [31:0]         push_flags;
    logic                cancel;
    logic                inta_req;
    logic                vec_valid;
    logic [7:0]          vec_out;
    iedisp_cls_e         cls_out;
    logic                rsvd_out;
    logic [TBL_OFS_W-1:0] tbl_ofs;
    logic                resume_valid;
    logic [IP_W-1:0]     resume_ip;
  } iedisp_state_s;

  iedisp_state_s st_r;
  iedisp_state_s st_nxt;

  iedisp_cls_e cls_cur;
  logic        rsvd_cur;
  logic        boundary;
  logic        nmi_rise;
  logic        take_exc;
  logic        take_soft;
  logic        take_dtrap;
  logic        take_dfault;
  logic        take_nmi;
  logic        take_irq;
  logic        take_any;

  // ----------------------------------------------------------------------
  // Classification of the held vector
  // ----------------------------------------------------------------------
  iedisp_classify iedisp_classify_inst (
    .vec       (st_r.vec),
    .is_hw     (st_r.src_hw),
    .is_soft   (st_r.src_soft),
    .dbg_fault (st_r.src_dbgf),
    .cls       (cls_cur),
    .reserved  (rsvd_cur)
  );

  // ----------------------------------------------------------------------
  // Request ranking
  // ----------------------------------------------------------------------
  // Exceptions of the running instruction come first, then at a boundary
  // debug trap, debug fault, non-maskable and finally maskable requests
  always_comb begin
    boundary    = instr_boundary || rep_window;
    nmi_rise    = (st_r.nmi_sync[1] == st_r.nmi_sync[2]) && st_r.nmi_sync[2]
                  && !st_r.nmi_lvl;
    take_exc    = (st_r.st == ST_IDLE) && exc_valid;
    take_soft   = (st_r.st == ST_IDLE) && !exc_valid && soft_valid;
    take_dtrap  = (st_r.st == ST_IDLE) && !exc_valid && !soft_valid && boundary
                  && debug_trap;
    take_dfault = (st_r.st == ST_IDLE) && !exc_valid && !soft_valid && boundary
                  && !debug_trap && debug_fault;
    take_nmi    = (st_r.st == ST_IDLE) && !exc_valid && !soft_valid && boundary
                  && !debug_trap && !debug_fault
                  && st_r.nmi_pend && !st_r.nmi_active;
    take_irq    = (st_r.st == ST_IDLE) && !exc_valid && !soft_valid && boundary
                  && !debug_trap && !debug_fault
                  && !(st_r.nmi_pend && !st_r.nmi_active)
                  && st_r.irq_lvl && st_r.flags[IF_POS];
    take_any    = take_exc || take_soft || take_dtrap || take_dfault
                  || take_nmi || take_irq;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // Pins pass three flops; a change counts once the last two agree
    st_nxt.nmi_sync = {st_r.nmi_sync[1:0], nmi_pin};
    st_nxt.irq_sync = {st_r.irq_sync[1:0], maskable_irq_in};
    if (st_r.nmi_sync[1] == st_r.nmi_sync[2]) begin
      st_nxt.nmi_lvl = st_r.nmi_sync[2];
    end
    if (st_r.irq_sync[1] == st_r.irq_sync[2]) begin
      st_nxt.irq_lvl = st_r.irq_sync[2];
    end

    // One-cycle pulses default low
    st_nxt.push_valid   = 1'b0;
    st_nxt.cancel       = 1'b0;
    st_nxt.vec_valid    = 1'b0;
    st_nxt.resume_valid = 1'b0;

    // A rising request latches once; a new edge wins over the take
    st_nxt.nmi_pend = nmi_rise || (st_r.nmi_pend && !take_nmi);

    // Flags written by the core when nothing overrides them
    if (flags_wr_en) begin
      st_nxt.flags = flags_wr_data;
    end

    // Interrupt return reopens the non-maskable path and restores state
    if (interrupt_return_instr) begin
      st_nxt.flags        = interrupt_return_instr_flags;
      st_nxt.nmi_active   = 1'b0;
      st_nxt.resume_valid = 1'b1;
      st_nxt.resume_ip    = interrupt_return_instr_ip;
    end

    unique case (st_r.st)
      ST_IDLE: begin
        if (take_any) begin
          st_nxt.st       = ST_PUSH;
          st_nxt.src_hw   = take_nmi || take_irq;
          st_nxt.src_nmi  = take_nmi;
          st_nxt.src_soft = take_soft;
          st_nxt.src_dbgf = take_dfault;
          st_nxt.at_rep   = rep_window && !instr_boundary;
          st_nxt.prot     = prot_mode;
          st_nxt.ip_here  = cur_ip;
          st_nxt.ip_next  = next_ip;
          // Vector known now for everything but the maskable request
          if (take_exc) begin
            st_nxt.vec = exc_vector;
          end else if (take_soft) begin
            st_nxt.vec = soft_one_byte ? VEC_BREAK : soft_vector;
          end else if (take_dtrap || take_dfault) begin
            st_nxt.vec = VEC_DEBUG;
          end else if (take_nmi) begin
            st_nxt.vec = VEC_NMI;
          end else begin
            st_nxt.vec = 8'h00;
          end
          if (take_nmi) begin
            st_nxt.nmi_active = 1'b1;
          end
        end
      end

      ST_PUSH: begin
        // Return state goes out before the vector is fetched
        st_nxt.push_valid = 1'b1;
        st_nxt.push_flags = st_r.flags;
        if (st_r.src_hw) begin
          // Window inside a string move resumes the same instruction
          st_nxt.push_ip = st_r.at_rep ? st_r.ip_here : st_r.ip_next;
        end else if (cls_cur == CLS_TRAP) begin
          st_nxt.push_ip = st_r.ip_next;
        end else begin
          st_nxt.push_ip = st_r.ip_here;
          st_nxt.cancel  = 1'b1;
        end
        // Handler entry masks further maskable requests
        st_nxt.flags[IF_POS] = 1'b0;
        if (st_r.src_hw && !st_r.src_nmi) begin
          st_nxt.st       = ST_ACK;
          st_nxt.inta_req = 1'b1;
        end else begin
          st_nxt.st = ST_LOAD;
        end
      end

      ST_ACK: begin
        // Held until the bus unit returns the controller's vector
        if (inta_done) begin
          st_nxt.vec      = inta_vector;
          st_nxt.inta_req = 1'b0;
          st_nxt.st       = ST_LOAD;
        end
      end

      ST_LOAD: begin
        st_nxt.vec_valid = 1'b1;
        st_nxt.vec_out   = st_r.vec;
        st_nxt.cls_out   = cls_cur;
        st_nxt.rsvd_out  = rsvd_cur;
        // Offset into the table scales with the entry size of the mode
        st_nxt.tbl_ofs   = st_r.prot
          ? (TBL_OFS_W'(st_r.vec) << ENTRY_SHIFT_PROT)
          : (TBL_OFS_W'(st_r.vec) << ENTRY_SHIFT_REAL);
        st_nxt.st        = ST_IDLE;
      end
    endcase

    st_nxt.busy = (st_nxt.st != ST_IDLE);
  end

  // ----------------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r       <= '0;
      st_r.st    <= ST_IDLE;
      st_r.flags <= FLAGS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign busy                 = st_r.busy;
  assign push_valid           = st_r.push_valid;
  assign push_ip              = st_r.push_ip;
  assign push_flags           = st_r.push_flags;
  assign cancel_instr         = st_r.cancel;
  assign inta_req             = st_r.inta_req;
  assign vec_valid            = st_r.vec_valid;
  assign vec_num              = st_r.vec_out;
  assign vec_class            = st_r.cls_out;
  assign vec_reserved         = st_r.rsvd_out;
  assign table_offset         = st_r.tbl_ofs;
  assign resume_valid         = st_r.resume_valid;
  assign resume_ip            = st_r.resume_ip;
  assign processor_flags_word = st_r.flags;
  assign nmi_in_service       = st_r.nmi_active;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_push_then_load;
    push_valid ##1 vec_valid;
  endsequence

  sequence s_nmi_entry;
    push_valid ##1 (vec_valid && vec_num == VEC_NMI && vec_class == CLS_MASKABLE_IRQ_IN);
  endsequence

  nmi_vector_two_a: assert property (
    $rose(nmi_in_service) |-> ##1 s_nmi_entry)
    else $error("non-maskable entry did not load vector 2");

  nmi_no_ack_a: assert property (
    $rose(nmi_in_service) |-> (!inta_req) [*3])
    else $error("acknowledge sequence run for non-maskable request");

  if_cleared_entry_a: assert property (
    push_valid |-> !processor_flags_word[IF_POS] && push_flags == $past(st_r.flags))
    else $error("interrupt enable not cleared on handler entry");

  interrupt_return_instr_restore_a: assert property (
    interrupt_return_instr && st_r.st != ST_PUSH
      |=> resume_valid && resume_ip == $past(interrupt_return_instr_ip)
          && processor_flags_word == $past(interrupt_return_instr_flags))
    else $error("interrupt return did not restore state");

  page_fault_ip_a: assert property (
    st_r.st == ST_IDLE && exc_valid && exc_vector == VEC_PAGE
      |-> ##2 (push_valid && cancel_instr && push_ip == $past(cur_ip, 2)) ##1 vec_valid)
    else $error("page fault return address not the faulting instruction");

  soft_trap_ip_a: assert property (
    st_r.st == ST_IDLE && !exc_valid && soft_valid && !soft_one_byte
      |-> ##2 (push_ip == $past(next_ip, 2) && !cancel_instr)
          ##1 (vec_valid && vec_class == CLS_TRAP && vec_num == $past(soft_vector, 3)))
    else $error("software interrupt not reported as a trap");

  breakpoint_vec_a: assert property (
    st_r.st == ST_IDLE && !exc_valid && soft_valid && soft_one_byte
      |-> ##2 s_push_then_load ##0 (vec_num == VEC_BREAK && vec_class == CLS_TRAP))
    else $error("breakpoint did not use vector 3");

  irq_gate_a: assert property (
    $rose(inta_req) |-> $past(st_r.flags[IF_POS], 2) && $past(st_r.irq_lvl, 2)
                        && $past(instr_boundary || rep_window, 2))
    else $error("maskable request taken while disabled or mid-instruction");

  ack_vector_a: assert property (
    inta_req && inta_done |-> ##2 (vec_valid && vec_num == $past(inta_vector, 2)))
    else $error("controller vector not used");

  nmi_held_a: assert property (
    take_nmi ##1 (!interrupt_return_instr) [*3] |=> nmi_in_service && !take_nmi)
    else $error("non-maskable service ended without a return");

endmodule

// File: iedisp_pic_model.sv
// Behavioural interrupt controller facing the dispatch block.
// Assumes the bench pulses raise_irq or raise_nmi for one core_clk cycle.
`timescale 1ns/10ps
module iedisp_pic_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  // Bench commands
  input  wire logic       raise_irq,
  input  wire logic       raise_nmi,
  input  wire logic [7:0] irq_vec,
  // Request and acknowledge lines
  input  wire logic       inta_req,
  output logic            maskable_irq_in,
  output logic            nmi_pin,
  output logic            inta_done,
  output logic [7:0]      inta_vector
);
  logic [3:0] nmi_cnt;
  logic [1:0] ack_cnt;
  assign nmi_pin = (nmi_cnt != 4'h0);
  // Request held until acknowledged; vector bus toggles while not valid
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      maskable_irq_in <= 1'b0;
      nmi_cnt         <= 4'h0;
      ack_cnt         <= 2'h0;
      inta_done       <= 1'b0;
      inta_vector     <= 8'h00;
    end else begin
      if (raise_irq) maskable_irq_in <= 1'b1;
      else if (inta_done) maskable_irq_in <= 1'b0;
      nmi_cnt <= raise_nmi ? 4'h8 : nmi_cnt - {3'h0, nmi_pin};
      ack_cnt <= !inta_req ? 2'h0 : (ack_cnt == 2'h3 ? 2'h3 : ack_cnt + 2'h1);
      inta_done <= inta_req && ack_cnt == 2'h1;
      inta_vector <= (inta_req && ack_cnt == 2'h1) ? irq_vec : ~inta_vector;
    end
  end
endmodule

// File: iedisp_pkg.sv
// Shared constants, types and the vector classifier of the interrupt dispatch block.
// Assumes a core that reports exceptions by vector number and a separate
// bus unit that runs the interrupt acknowledge sequence on request.

`timescale 1ns/10ps

package iedisp_pkg;

  // ----------------------------------------------------------------------
  // Vector numbers
  // ----------------------------------------------------------------------
  localparam int unsigned VEC_COUNT      = 256;
  localparam logic [7:0]  VEC_DIVIDE     = 8'h00;
  localparam logic [7:0]  VEC_DEBUG      = 8'h01;
  localparam logic [7:0]  VEC_NMI        = 8'h02;
  localparam logic [7:0]  VEC_BREAK      = 8'h03;
  localparam logic [7:0]  VEC_OVERFLOW   = 8'h04;
  localparam logic [7:0]  VEC_BOUNDS     = 8'h05;
  localparam logic [7:0]  VEC_OPCODE     = 8'h06;
  localparam logic [7:0]  VEC_NODEV      = 8'h07;
  localparam logic [7:0]  VEC_DOUBLE     = 8'h08;
  localparam logic [7:0]  VEC_OVERRUN    = 8'h09;
  localparam logic [7:0]  VEC_TSS        = 8'h0a;
  localparam logic [7:0]  VEC_PAGE       = 8'h0e;
  localparam logic [7:0]  VEC_RSVD15     = 8'h0f;
  localparam logic [7:0]  VEC_COPROC     = 8'h10;
  localparam logic [7:0]  VEC_USER_FIRST = 8'h20;

  // ----------------------------------------------------------------------
  // Flags word and table layout
  // ----------------------------------------------------------------------
  localparam logic [31:0] FLAGS_RESET      = 32'h0000_0002;
  localparam int unsigned IF_POS_DEFAULT   = 9;
  localparam int unsigned TBL_OFS_W        = 11;
  localparam int unsigned ENTRY_SHIFT_REAL = 2;  // 4 byte entries
  localparam int unsigned ENTRY_SHIFT_PROT = 3;  // 8 byte entries

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {CLS_FAULT, CLS_TRAP, CLS_ABORT, CLS_MASKABLE_IRQ_IN} iedisp_cls_e;
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_ACK, ST_LOAD} iedisp_state_e;

endpackage

// Maps a vector and its source onto the way it is reported
module iedisp_classify
  import iedisp_pkg::*;
(
  // Vector and source
  input  wire logic [7:0]  vec,
  input  wire logic        is_hw,
  input  wire logic        is_soft,
  input  wire logic        dbg_fault,
  // Classification
  output iedisp_cls_e      cls,
  output logic             reserved
);

  // ----------------------------------------------------------------------
  // Class table
  // ----------------------------------------------------------------------
  // Reserved vectors are handled like faults so that a retry stays possible
  always_comb begin
    reserved = ((vec == VEC_RSVD15) || (vec > VEC_COPROC && vec < VEC_USER_FIRST))
               && !is_soft && !is_hw;
    if (is_hw) begin
      cls = CLS_MASKABLE_IRQ_IN;
    end else if (is_soft) begin
      cls = CLS_TRAP;
    end else begin
      unique case (vec)
        VEC_DEBUG:    cls = dbg_fault ? CLS_FAULT : CLS_TRAP;
        VEC_BREAK:    cls = CLS_TRAP;
        VEC_OVERFLOW: cls = CLS_TRAP;
        VEC_DOUBLE:   cls = CLS_ABORT;
        VEC_OVERRUN:  cls = CLS_ABORT;
        default:      cls = CLS_FAULT;
      endcase
    end
  end

endmodule

// File: iedisp_tb_top.sv
// Self-checking bench for the dispatch core with a controller model.
// Assumes the package constants and a 100 MHz core_clk.
`timescale 1ns/10ps
module iedisp_tb_top
  import iedisp_pkg::*;
();
  logic core_clk, arst_n, instr_boundary, rep_window, prot_mode, exc_valid, soft_valid;
  logic soft_one_byte, debug_trap, debug_fault, flags_wr_en, interrupt_return_instr;
  logic raise_irq, raise_nmi, nmi_pin, maskable_irq_in, inta_done, busy, push_valid;
  logic cancel_instr, inta_req, vec_valid, vec_reserved, resume_valid, nmi_in_service;
  logic [31:0] cur_ip, next_ip, flags_wr_data, interrupt_return_instr_ip, interrupt_return_instr_flags, push_ip, push_flags;
  logic [31:0] resume_ip, processor_flags_word, cap_ip;
  logic [7:0] exc_vector, soft_vector, inta_vector, vec_num;
  logic [TBL_OFS_W-1:0] table_offset;
  iedisp_cls_e vec_class;
  logic cap_cancel;
  int errors, check_count;
  logic [7:0] ev [11] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0d,
                          8'h0e, 8'h0f, 8'h1f};

  iedisp_core iedisp_core_inst (.core_clk, .arst_n, .nmi_pin, .maskable_irq_in,
    .instr_boundary, .rep_window, .cur_ip, .next_ip, .prot_mode, .exc_valid, .exc_vector,
    .soft_valid, .soft_vector, .soft_one_byte, .debug_trap, .debug_fault, .flags_wr_en,
    .flags_wr_data, .interrupt_return_instr, .interrupt_return_instr_ip, .interrupt_return_instr_flags, .inta_done, .inta_vector,
    .busy, .push_valid, .push_ip, .push_flags, .cancel_instr, .inta_req, .vec_valid,
    .vec_num, .vec_class, .vec_reserved, .table_offset, .resume_valid, .resume_ip,
    .processor_flags_word, .nmi_in_service);
  iedisp_pic_model iedisp_pic_model_inst (.core_clk, .arst_n, .raise_irq, .raise_nmi,
    .irq_vec(8'h41), .inta_req, .maskable_irq_in, .nmi_pin, .inta_done, .inta_vector);

  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One strobe high for exactly one cycle, raised and dropped at rising edges
  task pulse(input string w);
    for (int k = 1; k >= 0; k--) begin
      @(posedge core_clk);
      case (w)
        "flags": flags_wr_en <= k[0];
        "soft":  soft_valid <= k[0];
        "exc":   exc_valid <= k[0];
        "interrupt_return_instr":  interrupt_return_instr <= k[0];
        "rep":   rep_window <= k[0];
        default: instr_boundary <= k[0];
      endcase
    end
  endtask
  // Bounded wait for the vector, capturing what was pushed on the way
  task wait_vec;
    cap_cancel = 1'b0;
    for (int i = 0; i < 60 && vec_valid !== 1'b1; i++) begin
      @(posedge core_clk) #1;
      if (push_valid === 1'b1) begin
        cap_ip = push_ip;
        cap_cancel = cancel_instr;
      end
    end
    if (vec_valid !== 1'b1) begin
      errors++;
      tally_and_finish;
    end
  endtask
  task wr_flags(input logic [31:0] d);
    @(posedge core_clk) flags_wr_data <= d;
    pulse("flags");
  endtask

  // Two-byte and one-byte software interrupts taken as traps
  task sc_soft;
    @(posedge core_clk) soft_vector <= 8'hc5;
    pulse("soft");
    wait_vec;
    chk("soft vec", vec_num, 8'hc5);
    chk("soft cls", vec_class, CLS_TRAP);
    chk("soft ofs", table_offset, 11'h314);
    chk("soft ret", cap_ip, next_ip);
    chk("saved if", push_flags[9], 1'b1);
    chk("if clr", processor_flags_word[9], 1'b0);
    @(posedge core_clk) soft_one_byte <= 1'b1;
    pulse("soft");
    wait_vec;
    chk("bp vec", vec_num, 8'h03);
    chk("bp ret", cap_ip, next_ip);
  endtask

  // Debug trap outranks debug fault at a boundary; both use vector 1
  task sc_dbg;
    @(posedge core_clk) debug_trap <= 1'b1;
    debug_fault <= 1'b1;
    pulse("bound");
    wait_vec;
    chk("dtrap vec", vec_num, VEC_DEBUG);
    chk("dtrap cls", vec_class, CLS_TRAP);
    chk("dtrap ret", cap_ip, next_ip);
    @(posedge core_clk) debug_trap <= 1'b0;
    pulse("bound");
    wait_vec;
    chk("dfault cls", vec_class, CLS_FAULT);
    chk("dfault ret", cap_ip, cur_ip);
    chk("dfault cancel", cap_cancel, 1'b1);
    @(posedge core_clk) debug_fault <= 1'b0;
  endtask

  // Exception table across classes, alternating table modes
  task sc_exc;
    logic trap;
    for (int i = 0; i < 11; i++) begin
      trap = (ev[i] == 8'h04);
      @(posedge core_clk) exc_vector <= ev[i];
      prot_mode <= i[0];
      pulse("exc");
      wait_vec;
      chk("exc cls", vec_class, trap ? CLS_TRAP : (ev[i] == 8'h08 || ev[i] == 8'h09) ?
          CLS_ABORT : CLS_FAULT);
      chk("exc ret", cap_ip, trap ? next_ip : cur_ip);
      chk("exc cancel", cap_cancel, !trap);
      chk("exc rsvd", vec_reserved, ev[i] == 8'h0f || ev[i] > 8'h10);
      chk("exc ofs", table_offset, i[0] ? {ev[i], 3'h0} : {1'b0, ev[i], 2'h0});
    end
  endtask

  // Non-maskable beats maskable; maskable follows once return restores enable
  task sc_nmi;
    wr_flags(32'h0000_0202);
    @(posedge core_clk) raise_irq <= 1'b1;
    raise_nmi <= 1'b1;
    @(posedge core_clk) raise_irq <= 1'b0;
    raise_nmi <= 1'b0;
    repeat (6) @(posedge core_clk);
    pulse("bound");
    wait_vec;
    chk("nmi vec", vec_num, VEC_NMI);
    chk("nmi ack", inta_req, 1'b0);
    chk("nmi if", processor_flags_word[9], 1'b0);
    chk("nmi svc", nmi_in_service, 1'b1);
    pulse("bound");
    repeat (4) @(posedge core_clk);
    #1;
    chk("masked", busy, 1'b0);
    @(posedge core_clk) interrupt_return_instr_flags <= 32'h0000_0202;
    pulse("interrupt_return_instr");
    #1;
    chk("resume v", resume_valid, 1'b1);
    chk("resume", resume_ip, interrupt_return_instr_ip);
    chk("if back", processor_flags_word[9], 1'b1);
    pulse("rep");
    wait_vec;
    chk("irq vec", vec_num, 8'h41);
    chk("irq cls", vec_class, CLS_MASKABLE_IRQ_IN);
    chk("rep ret", cap_ip, cur_ip);
  endtask

  // A second non-maskable edge during service waits for the return
  task sc_nmi_nest;
    @(posedge core_clk) raise_nmi <= 1'b1;
    @(posedge core_clk) raise_nmi <= 1'b0;
    repeat (6) @(posedge core_clk);
    pulse("bound");
    wait_vec;
    chk("nest first", vec_num, VEC_NMI);
    repeat (4) @(posedge core_clk);
    raise_nmi <= 1'b1;
    @(posedge core_clk) raise_nmi <= 1'b0;
    repeat (6) @(posedge core_clk);
    pulse("bound");
    #1;
    chk("nest held", busy, 1'b0);
    pulse("interrupt_return_instr");
    pulse("bound");
    wait_vec;
    chk("nest latched", vec_num, VEC_NMI);
    chk("nest svc", nmi_in_service, 1'b1);
  endtask

  // Main sequence
  initial begin
    {arst_n, instr_boundary, rep_window, prot_mode, exc_valid, soft_valid} = '0;
    {soft_one_byte, debug_trap, debug_fault, flags_wr_en, interrupt_return_instr} = '0;
    {raise_irq, raise_nmi, exc_vector, soft_vector, flags_wr_data} = '0;
    cur_ip = 32'h0000_1000;
    next_ip = 32'h0000_1003;
    interrupt_return_instr_ip = 32'h0000_2000;
    interrupt_return_instr_flags = 32'h0;
    errors = 0;
    check_count = 0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    chk("rst flags", processor_flags_word, FLAGS_RESET);
    wr_flags(32'h0000_0202);
    sc_soft;
    sc_dbg;
    sc_exc;
    sc_nmi;
    sc_nmi_nest;
    tally_and_finish;
  end
endmodule
